// *** shared/alarm_log_pkg.sv ***
/*
 * alarm_log_pkg: constants, field layouts and carrier types for the alarm event recorder.
 * assumes a 10 MHz system clock and a real-time clock that gives one-cycle minute ticks.
 */
package alarm_log_pkg;

    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned KEY_HOLD_MS     = 1000;
    localparam int unsigned CONFIRM_MS      = 1000;
    localparam int unsigned KEY_HOLD_CYCLES = (CLK_HZ / 1000) * KEY_HOLD_MS;
    localparam int unsigned CONFIRM_CYCLES  = (CLK_HZ / 1000) * CONFIRM_MS;

    localparam int unsigned LOG_DEPTH   = 10;
    localparam int unsigned NUM_CHAN    = 6;
    localparam int unsigned NUM_KEYS    = 2;
    localparam int unsigned HOLD_W      = 24;

    // channel order inside the recorder
    localparam int unsigned CH_H1  = 0;
    localparam int unsigned CH_L1  = 1;
    localparam int unsigned CH_H2  = 2;
    localparam int unsigned CH_L2  = 3;
    localparam int unsigned CH_PF  = 4;
    localparam int unsigned CH_EXT = 5;

    // entry type codes
    localparam logic [2:0] FIRST_HIGH_TEMP_CODE  = 3'h1;
    localparam logic [2:0] FIRST_LOW_TEMP_CODE   = 3'h2;
    localparam logic [2:0] SECOND_HIGH_TEMP_CODE = 3'h3;
    localparam logic [2:0] SECOND_LOW_TEMP_CODE  = 3'h4;
    localparam logic [2:0] POWER_FAIL_CODE       = 3'h5;
    localparam logic [2:0] EXTERNAL_ALARM_CODE   = 3'h6;

    localparam logic [15:0] TEMP_UNAVAILABLE = 16'h8000;
    localparam logic [7:0]  OFF_SETTING      = 8'h00;

    // external alarm modes that are logged
    localparam logic [3:0] EXT_MODE_A = 4'h4;
    localparam logic [3:0] EXT_MODE_B = 4'h5;

    // key function codes
    localparam logic [3:0] KEY_FN_LOG_CLEAR  = 4'h6;
    localparam logic [3:0] KEY_FN_REC_TOGGLE = 4'h7;

    // register byte addresses
    localparam logic [7:0] REG_CTRL       = 8'h00;
    localparam logic [7:0] REG_TEMP1_MIN  = 8'h04;
    localparam logic [7:0] REG_TEMP2_MIN  = 8'h08;
    localparam logic [7:0] REG_PF_MIN     = 8'h0C;
    localparam logic [7:0] REG_EXT_MIN    = 8'h10;
    localparam logic [7:0] REG_KEY_FUNC   = 8'h14;
    localparam logic [7:0] REG_EXT_MODE   = 8'h18;
    localparam logic [7:0] REG_STATUS     = 8'h1C;
    localparam logic [7:0] REG_LOST       = 8'h20;
    localparam logic [3:0] ENTRY_BASE_HI  = 4'h4;
    localparam logic [1:0] ENTRY_WORDS    = 2'h3;

    // control register fields
    localparam int unsigned CTRL_REC_EN_BIT    = 0;
    localparam int unsigned CTRL_CLEAR_BIT     = 1;
    localparam int unsigned CTRL_LOST_CLR_BIT  = 2;
    localparam logic        REC_EN_RESET       = 1'b1;

    localparam logic [6:0]  MIN_PER_HOUR = 7'h3C;

    typedef struct packed {
        logic [6:0] year;
        logic [3:0] month;
        logic [4:0] day;
        logic [4:0] hour;
        logic [5:0] minute;
    } rtc_time_type;

    typedef struct packed {
        logic [2:0]   code;
        rtc_time_type start;
        logic [7:0]   dur_hours;
        logic [5:0]   dur_minutes;
        logic [15:0]  temp;
    } log_entry_type;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_type;

    typedef enum logic [1:0] {
        DISP_NONE,
        DISP_DASHES,
        DISP_REC_ON,
        DISP_REC_OFF
    } disp_type;

endpackage : alarm_log_pkg

// *** core/alarm_event_recorder.sv ***
/*
 * alarm_event_recorder: ten-entry alarm log with per-class qualification and key commands.
 * assumes alarm levels, probe reading, rtc time and minute tick come from logic on i_clk_sys;
 * the mains-ok, digital input and key pins are asynchronous and are synchronised here.
 */
// Functional notes
// [RULE1] temperature pair alarm logged only if its minimum time is set and reached
// [RULE2] first setting covers first high/low, second the second pair; off disables pair
// [RULE3] temperature entry holds code, start time, duration and peak temperature
// [RULE4] mains failure ends running temperature or input alarms at failure start
// [RULE5] temperature alarm still active at power return starts a new episode
// [RULE6] power failure logged only when outage exceeds its minimum time
// [RULE7] power failure minimum time off means no power failure entries
// [RULE8] power failure entry holds code, start, duration, probe temperature at return
// [RULE9] input alarm logged only in mode 4 or 5 and longer than its minimum
// [RULE10] input minimum time off means no input alarm entries
// [RULE11] input alarm entry holds code, start, duration, probe temperature at end
// [RULE12] clear key held one second erases log, dashes shown about one second
// [RULE13] toggle key held one second flips recording, state shown about one second
// [RULE14] log keeps ten newest entries ordered newest first
// [RULE15] eleventh entry drops the oldest and bumps the lost counter
// [RULE16] durations counted in rtc minutes, thresholds compared in minutes
`timescale 1ns/1ps
`default_nettype none

module alarm_event_recorder
    import alarm_log_pkg::*;
#(
    parameter int unsigned KEY_HOLD = KEY_HOLD_CYCLES,
    parameter int unsigned CONFIRM  = CONFIRM_CYCLES
) (
    input  wire logic          i_clk_sys,
    input  wire logic          i_reset,
    input  wire reg_req_type   i_req,
    output var  logic [31:0]   o_rd_data,
    input  wire rtc_time_type  i_rtc_time,
    input  wire logic          i_rtc_minute_tick,
    input  wire logic [3:0]    i_temp_alarm,
    input  wire logic [15:0]   i_probe_temp,
    input  wire logic          i_probe_valid,
    input  wire logic          i_mains_ok,
    input  wire logic          i_ext_input,
    input  wire logic [1:0]    i_key,
    output var  disp_type      o_display,
    output var  logic          o_rec_enable,
    output var  logic [3:0]    o_entry_count
);

    // synchronisers: stage one feeds stage two only
    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            sync1_ff <= 4'h1; // mains pin idles high, a low reset would fake an outage
            sync2_ff <= 4'h1;
        end else begin
            sync1_ff <= {i_key, i_ext_input, i_mains_ok};
            sync2_ff <= sync1_ff;
        end
    end
    logic       mains_ok;
    logic       ext_in;
    logic [1:0] key_in;
    assign mains_ok = sync2_ff[0];
    assign ext_in   = sync2_ff[1];
    assign key_in   = sync2_ff[3:2];
    // configuration registers
    logic [7:0] temp1_min_ff;
    logic [7:0] temp2_min_ff;
    logic [7:0] pf_min_ff;
    logic [7:0] ext_min_ff;
    logic [7:0] key_func_ff;
    logic [3:0] ext_mode_ff;
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            temp1_min_ff <= 8'h00;
            temp2_min_ff <= 8'h00;
            pf_min_ff    <= 8'h00;
            ext_min_ff   <= 8'h00;
            key_func_ff  <= 8'h00;
            ext_mode_ff  <= 4'h0;
        end else if (i_req.wr) begin
            case (i_req.addr)
                REG_TEMP1_MIN: temp1_min_ff <= i_req.wdata[7:0];
                REG_TEMP2_MIN: temp2_min_ff <= i_req.wdata[7:0];
                REG_PF_MIN:    pf_min_ff    <= i_req.wdata[7:0];
                REG_EXT_MIN:   ext_min_ff   <= i_req.wdata[7:0];
                REG_KEY_FUNC:  key_func_ff  <= i_req.wdata[7:0];
                REG_EXT_MODE:  ext_mode_ff  <= i_req.wdata[3:0];
                default: ;
            endcase
        end
    end
    logic ctrl_wr;
    assign ctrl_wr = i_req.wr && (i_req.addr == REG_CTRL);
    // key hold detection, one command per press
    logic [HOLD_W-1:0] hold_ff  [NUM_KEYS];
    logic [NUM_KEYS-1:0] fired_ff;
    logic [NUM_KEYS-1:0] key_fire;
    genvar k;
    generate
        for (k = 0; k < NUM_KEYS; k++) begin : g_key
            always_ff @(posedge i_clk_sys or posedge i_reset) begin
                if (i_reset) begin
                    hold_ff[k]  <= '0;
                    fired_ff[k] <= 1'b0;
                end else if (!key_in[k]) begin
                    hold_ff[k]  <= '0;
                    fired_ff[k] <= 1'b0;
                end else if (!fired_ff[k]) begin
                    if (hold_ff[k] == HOLD_W'(KEY_HOLD - 1)) begin
                        fired_ff[k] <= 1'b1;
                    end
                    hold_ff[k] <= hold_ff[k] + 1'b1;
                end
            end
            assign key_fire[k] = key_in[k] && !fired_ff[k]
                                 && (hold_ff[k] == HOLD_W'(KEY_HOLD - 1));
        end
    endgenerate
    logic key_clear;
    logic key_toggle;
    assign key_clear  = (key_fire[0] && key_func_ff[3:0] == KEY_FN_LOG_CLEAR)
                      || (key_fire[1] && key_func_ff[7:4] == KEY_FN_LOG_CLEAR);
    assign key_toggle = (key_fire[0] && key_func_ff[3:0] == KEY_FN_REC_TOGGLE)
                      || (key_fire[1] && key_func_ff[7:4] == KEY_FN_REC_TOGGLE);
    logic log_clear;
    assign log_clear = key_clear || (ctrl_wr && i_req.wdata[CTRL_CLEAR_BIT]); // [RULE12]
    // recording enable
    logic rec_en_ff;
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            rec_en_ff <= REC_EN_RESET;
        end else if (key_toggle) begin
            rec_en_ff <= !rec_en_ff; // [RULE13]
        end else if (ctrl_wr) begin
            rec_en_ff <= i_req.wdata[CTRL_REC_EN_BIT];
        end
    end
    assign o_rec_enable = rec_en_ff;
    // confirmation display, held for the confirm time
    logic [HOLD_W-1:0] disp_cnt_ff;
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_display   <= DISP_NONE;
            disp_cnt_ff <= '0;
        end else if (key_clear) begin
            o_display   <= DISP_DASHES; // [RULE12]
            disp_cnt_ff <= HOLD_W'(CONFIRM - 1);
        end else if (key_toggle) begin
            o_display   <= rec_en_ff ? DISP_REC_OFF : DISP_REC_ON; // [RULE13]
            disp_cnt_ff <= HOLD_W'(CONFIRM - 1);
        end else if (disp_cnt_ff != '0) begin
            disp_cnt_ff <= disp_cnt_ff - 1'b1;
        end else begin
            o_display <= DISP_NONE;
        end
    end
    // per-channel alarm levels; mains loss ends every other episode
    logic [NUM_CHAN-1:0] lvl;
    logic                ext_mode_ok;
    assign ext_mode_ok = (ext_mode_ff == EXT_MODE_A) || (ext_mode_ff == EXT_MODE_B); // [RULE9]
    assign lvl[3:0]    = i_temp_alarm & {4{mains_ok}}; // [RULE4] [RULE5]
    assign lvl[CH_PF]  = !mains_ok;
    assign lvl[CH_EXT] = ext_in && ext_mode_ok && mains_ok; // [RULE4]
    logic [7:0] thr [NUM_CHAN];
    assign thr[CH_H1]  = temp1_min_ff; // [RULE2]
    assign thr[CH_L1]  = temp1_min_ff;
    assign thr[CH_H2]  = temp2_min_ff;
    assign thr[CH_L2]  = temp2_min_ff;
    assign thr[CH_PF]  = pf_min_ff;
    assign thr[CH_EXT] = ext_min_ff;
    localparam logic [2:0] CODES [NUM_CHAN] = '{FIRST_HIGH_TEMP_CODE, FIRST_LOW_TEMP_CODE,
        SECOND_HIGH_TEMP_CODE, SECOND_LOW_TEMP_CODE, POWER_FAIL_CODE, EXTERNAL_ALARM_CODE};
    logic [NUM_CHAN-1:0] act_ff;
    logic [NUM_CHAN-1:0] pend_ff;
    log_entry_type       pent_ff [NUM_CHAN];
    logic [NUM_CHAN-1:0] grant;
    logic [15:0] probe_or_na;
    assign probe_or_na = i_probe_valid ? i_probe_temp : TEMP_UNAVAILABLE; // [RULE8] [RULE11]
    genvar c;
    generate
        for (c = 0; c < NUM_CHAN; c++) begin : g_chan
            rtc_time_type start_ff;
            logic [5:0]   mins_ff;
            logic [7:0]   hrs_ff;
            logic [8:0]   tot_ff;
            logic [15:0]  peak_ff;
            logic         ended;
            logic         qual;
            logic [15:0]  end_temp;
            assign ended = act_ff[c] && !lvl[c];
            // temperature pairs need at least the minimum, the others strictly more
            if (c < 4) begin : g_tq
                assign qual     = (thr[c] != OFF_SETTING) && (tot_ff >= {1'b0, thr[c]}); // [RULE1]
                assign end_temp = peak_ff; // [RULE3]
            end else begin : g_oq
                assign qual     = (thr[c] != OFF_SETTING) && (tot_ff > {1'b0, thr[c]}); // [RULE6] [RULE7] [RULE9] [RULE10]
                assign end_temp = probe_or_na; // [RULE8] [RULE11]
            end
            always_ff @(posedge i_clk_sys or posedge i_reset) begin
                if (i_reset) begin
                    act_ff[c] <= 1'b0;
                    start_ff  <= '0;
                    mins_ff   <= 6'h00;
                    hrs_ff    <= 8'h00;
                    tot_ff    <= 9'h000;
                    peak_ff   <= 16'h0000;
                end else if (!act_ff[c]) begin
                    if (lvl[c]) begin
                        act_ff[c] <= 1'b1;
                        start_ff  <= i_rtc_time;
                        mins_ff   <= 6'h00;
                        hrs_ff    <= 8'h00;
                        tot_ff    <= 9'h000;
                        peak_ff   <= i_probe_temp;
                    end
                end else if (!lvl[c]) begin
                    act_ff[c] <= 1'b0;
                end else begin
                    if (i_rtc_minute_tick) begin // [RULE16]
                        if (tot_ff != 9'h1FF) begin
                            tot_ff <= tot_ff + 1'b1;
                        end
                        if (mins_ff == 6'(MIN_PER_HOUR - 1'b1)) begin
                            mins_ff <= 6'h00;
                            if (hrs_ff != 8'hFF) begin
                                hrs_ff <= hrs_ff + 1'b1;
                            end
                        end else begin
                            mins_ff <= mins_ff + 1'b1;
                        end
                    end
                    // high alarms keep the maximum, low alarms the minimum
                    if (c == CH_H1 || c == CH_H2) begin
                        if ($signed(i_probe_temp) > $signed(peak_ff)) begin
                            peak_ff <= i_probe_temp; // [RULE3]
                        end
                    end else if ($signed(i_probe_temp) < $signed(peak_ff)) begin
                        peak_ff <= i_probe_temp; // [RULE3]
                    end
                end
            end
            // a fresh qualifying end wins over the grant that empties the slot
            always_ff @(posedge i_clk_sys or posedge i_reset) begin
                if (i_reset) begin
                    pend_ff[c] <= 1'b0;
                    pent_ff[c] <= '0;
                end else if (ended && qual) begin
                    pend_ff[c] <= 1'b1;
                    pent_ff[c] <= '{code: CODES[c], start: start_ff, dur_hours: hrs_ff,
                                    dur_minutes: mins_ff, temp: end_temp}; // [RULE3] [RULE8] [RULE11]
                end else if (grant[c]) begin
                    pend_ff[c] <= 1'b0;
                end
            end
        end
    endgenerate
    // one commit per cycle, lowest channel first; held back while the log clears
    logic          commit;
    log_entry_type commit_entry;
    always_comb begin
        grant        = '0;
        commit       = 1'b0;
        commit_entry = '0;
        for (int i = NUM_CHAN - 1; i >= 0; i--) begin
            if (pend_ff[i] && !log_clear) begin
                grant        = '0;
                grant[i]     = 1'b1;
                commit       = 1'b1;
                commit_entry = pent_ff[i];
            end
        end
    end
    // log storage, index 0 is the newest
    log_entry_type log_ff [LOG_DEPTH];
    logic [3:0]    count_ff;
    logic [15:0]   lost_ff;
    logic          do_insert;
    assign do_insert = commit && rec_en_ff;
    genvar e;
    generate
        for (e = 0; e < LOG_DEPTH; e++) begin : g_log
            always_ff @(posedge i_clk_sys or posedge i_reset) begin
                if (i_reset) begin
                    log_ff[e] <= '0;
                end else if (log_clear) begin
                    log_ff[e] <= '0;
                end else if (do_insert) begin
                    if (e == 0) begin
                        log_ff[e] <= commit_entry; // [RULE14]
                    end else begin
                        log_ff[e] <= log_ff[e-1]; // [RULE14] [RULE15]
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            count_ff <= 4'h0;
        end else if (log_clear) begin
            count_ff <= 4'h0; // [RULE12]
        end else if (do_insert && count_ff != 4'(LOG_DEPTH)) begin
            count_ff <= count_ff + 1'b1;
        end
    end
    assign o_entry_count = count_ff;
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            lost_ff <= 16'h0000;
        end else if (do_insert && count_ff == 4'(LOG_DEPTH) && lost_ff != 16'hFFFF) begin
            lost_ff <= lost_ff + 1'b1; // [RULE15]
        end else if (ctrl_wr && i_req.wdata[CTRL_LOST_CLR_BIT]) begin
            lost_ff <= 16'h0000;
        end
    end
    // read port, data one cycle after the strobe
    logic [3:0]    rd_idx;
    logic [1:0]    rd_word;
    log_entry_type rd_ent;
    assign rd_idx  = i_req.addr[7:4] - ENTRY_BASE_HI;
    assign rd_word = i_req.addr[3:2];
    assign rd_ent  = log_ff[(rd_idx < 4'(LOG_DEPTH)) ? rd_idx : 4'h0];

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_rd_data <= 32'h0000_0000;
        end else if (!i_req.rd) begin
            o_rd_data <= 32'h0000_0000;
        end else if (i_req.addr[7:4] >= ENTRY_BASE_HI) begin
            // unused slots and words read as zero
            if (rd_idx >= 4'(LOG_DEPTH) || rd_idx >= count_ff || rd_word == ENTRY_WORDS
                    || i_req.addr[1:0] != 2'h0) begin
                o_rd_data <= 32'h0000_0000;
            end else if (rd_word == 2'h0) begin
                o_rd_data <= {13'h0000, rd_ent.code, rd_ent.start.year,
                              rd_ent.start.month, rd_ent.start.day};
            end else if (rd_word == 2'h1) begin
                o_rd_data <= {7'h00, rd_ent.start.hour, rd_ent.start.minute,
                              rd_ent.dur_hours, rd_ent.dur_minutes};
            end else begin
                o_rd_data <= {16'h0000, rd_ent.temp};
            end
        end else begin
            case (i_req.addr)
                REG_CTRL:      o_rd_data <= {31'h0000_0000, rec_en_ff};
                REG_TEMP1_MIN: o_rd_data <= {24'h00_0000, temp1_min_ff};
                REG_TEMP2_MIN: o_rd_data <= {24'h00_0000, temp2_min_ff};
                REG_PF_MIN:    o_rd_data <= {24'h00_0000, pf_min_ff};
                REG_EXT_MIN:   o_rd_data <= {24'h00_0000, ext_min_ff};
                REG_KEY_FUNC:  o_rd_data <= {24'h00_0000, key_func_ff};
                REG_EXT_MODE:  o_rd_data <= {28'h000_0000, ext_mode_ff};
                REG_STATUS:    o_rd_data <= {16'h0000, 2'h0, act_ff, 3'h0,
                                             rec_en_ff, count_ff};
                REG_LOST:      o_rd_data <= {16'h0000, lost_ff};
                default:       o_rd_data <= 32'h0000_0000;
            endcase
        end
    end

endmodule : alarm_event_recorder

`default_nettype wire

// *** test/alarm_event_recorder_asserts.sv ***
/*
 * alarm_event_recorder_asserts: port-level checks of the alarm recorder.
 * assumes it is bound to the recorder and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module alarm_event_recorder_asserts
    import alarm_log_pkg::*;
#(
    parameter int unsigned CONFIRM = CONFIRM_CYCLES
) (
    input wire logic        i_clk_sys,
    input wire logic        i_reset,
    input wire reg_req_type i_req,
    input wire logic [31:0] o_rd_data,
    input wire disp_type    o_display,
    input wire logic        o_rec_enable,
    input wire logic [3:0]  o_entry_count
);
    logic [31:0] disp_cnt_ff;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    // counts cycles a confirmation stays up; a counter keeps long holds cheap
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            disp_cnt_ff <= 32'h0;
        end else begin
            disp_cnt_ff <= (o_display == DISP_NONE) ? 32'h0 : disp_cnt_ff + 32'h1;
        end
    end
    a_rd_idle_zero: assert property (!$past(i_req.rd) |-> o_rd_data == 32'h0)
        else $error("read data not zero outside a read");
    a_count_max: assert property (o_entry_count <= 4'hA)
        else $error("entry count above ten");
    a_count_step: assert property ($changed(o_entry_count) |->
        o_entry_count == $past(o_entry_count) + 4'h1 || o_entry_count == 4'h0)
        else $error("entry count jumped");
    a_disp_hold: assert property (($past(o_display) == DISP_NONE &&
        o_display != DISP_NONE) |=> $stable(o_display) [*8])
        else $error("confirmation dropped early");
    a_disp_end: assert property (disp_cnt_ff <= CONFIRM + 1)
        else $error("confirmation shown too long");
    a_toggle_show: assert property (($changed(o_display) &&
        o_display inside {DISP_REC_ON, DISP_REC_OFF}) |->
        ##[0:1] (o_rec_enable == (o_display == DISP_REC_ON)))
        else $error("toggle display disagrees with recording state");
    a_rec_cause: assert property (($changed(o_rec_enable) && !$past(i_req.wr)) |->
        ##[0:1] (o_display inside {DISP_REC_ON, DISP_REC_OFF}))
        else $error("recording flipped without indication");
    a_clear_dash: assert property (($changed(o_display) && o_display == DISP_DASHES)
        |-> ##[0:1] (o_entry_count == 4'h0))
        else $error("log not empty after clear");
endmodule : alarm_event_recorder_asserts
bind alarm_event_recorder alarm_event_recorder_asserts #(.CONFIRM(CONFIRM))
    alarm_event_recorder_asserts_inst (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .i_req(i_req), .o_rd_data(o_rd_data), .o_display(o_display),
    .o_rec_enable(o_rec_enable), .o_entry_count(o_entry_count));
`default_nettype wire

// *** test/test_alarm_event_recorder.sv ***
/*
 * test_alarm_event_recorder: directed scenarios over registers, alarm pins and keys.
 * assumes the package and the checker bind are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
module test_alarm_event_recorder import alarm_log_pkg::*;;
    logic         i_clk_sys = 1'b0;
    logic         i_reset = 1'b1;
    reg_req_type  i_req = '0;
    logic [31:0]  o_rd_data;
    rtc_time_type i_rtc_time = '{7'h19, 4'h6, 5'h0F, 5'h0A, 6'h1E};
    logic         i_rtc_minute_tick = 1'b0;
    logic [3:0]   i_temp_alarm = 4'h0;
    logic [15:0]  i_probe_temp = 16'h0100;
    logic         i_probe_valid = 1'b1;
    logic         i_mains_ok = 1'b1;
    logic         i_ext_input = 1'b0;
    logic [1:0]   i_key = 2'h0;
    disp_type     o_display;
    logic         o_rec_enable;
    logic [3:0]   o_entry_count;
    int           num_errors = 0;
    int           num_checks = 0;
    int           cyc = 0;
    // short hold and confirm counts keep key scenarios brief
    alarm_event_recorder #(.KEY_HOLD(20), .CONFIRM(10)) alarm_event_recorder_inst (
        .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_req(i_req), .o_rd_data(o_rd_data),
        .i_rtc_time(i_rtc_time), .i_rtc_minute_tick(i_rtc_minute_tick),
        .i_temp_alarm(i_temp_alarm), .i_probe_temp(i_probe_temp),
        .i_probe_valid(i_probe_valid), .i_mains_ok(i_mains_ok), .i_ext_input(i_ext_input),
        .i_key(i_key), .o_display(o_display), .o_rec_enable(o_rec_enable),
        .o_entry_count(o_entry_count));
    always #50 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic tk(int n);
        repeat (n) @(posedge i_clk_sys);
    endtask : tk
    task automatic cnt(logic [3:0] n);
        #1 chk("entry count", {28'h0, n}, {28'h0, o_entry_count});
    endtask : cnt
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge i_clk_sys);
        i_req <= '{a, d, 1'b1, 1'b0};
        @(posedge i_clk_sys);
        i_req.wr <= 1'b0;
    endtask : wr
    task automatic rd(logic [7:0] a, logic [31:0] e);
        @(posedge i_clk_sys);
        i_req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge i_clk_sys);
        i_req.rd <= 1'b0;
        #1 chk("read data", e, o_rd_data);
    endtask : rd
    task automatic ticks(int n);
        repeat (n) begin
            i_rtc_minute_tick <= 1'b1;
            tk(1);
            i_rtc_minute_tick <= 1'b0;
            tk(1);
        end
    endtask : ticks
    task automatic lvl(int b, logic v);
        if (b < 4) i_temp_alarm[b] <= v;
        else if (b == 4) i_mains_ok <= !v;
        else i_ext_input <= v;
    endtask : lvl
    // probe starts high and ends low so the high peak differs from the low minimum and the end value, which are equal
    task automatic ep(int b, int n);
        @(posedge i_clk_sys);
        i_probe_temp <= 16'h0100;
        lvl(b, 1'b1);
        tk(3);
        ticks(n);
        i_probe_temp <= 16'h0050;
        tk(2);
        lvl(b, 1'b0);
        tk(6);
    endtask : ep
    task automatic ent(int n, logic [2:0] c, logic [5:0] m, logic [15:0] t);
        logic [7:0] a;
        a = 8'h40 + 8'(n * 16);
        rd(a, {13'h0, c, i_rtc_time.year, i_rtc_time.month, i_rtc_time.day});
        rd(a + 8'h4, {7'h0, i_rtc_time.hour, i_rtc_time.minute, 8'h00, m});
        rd(a + 8'h8, {16'h0, t});
    endtask : ent
    task automatic key(int k, disp_type d, int n);
        @(posedge i_clk_sys);
        i_key[k] <= 1'b1;
        tk(n);
        #1 chk("display", d, o_display);
        @(posedge i_clk_sys);
        i_key[k] <= 1'b0;
        tk(15);
    endtask : key
    task automatic s_temp();
        rd(REG_CTRL, 32'h1);
        rd(8'hFC, 32'h0);
        wr(REG_TEMP1_MIN, 32'h2);
        ep(0, 1);
        cnt(4'h0);
        ep(0, 2);
        ent(0, FIRST_HIGH_TEMP_CODE, 6'h2, 16'h0100);
        ep(1, 3);
        ent(0, FIRST_LOW_TEMP_CODE, 6'h3, 16'h0050);
        ep(2, 5);
        cnt(4'h2);
        wr(REG_TEMP2_MIN, 32'h1);
        ep(3, 1);
        ent(0, SECOND_LOW_TEMP_CODE, 6'h1, 16'h0050);
        ent(1, FIRST_LOW_TEMP_CODE, 6'h3, 16'h0050);
    endtask : s_temp
    task automatic s_pf();
        wr(REG_PF_MIN, 32'h1);
        ep(4, 1);
        cnt(4'h3);
        ep(4, 2);
        ent(0, POWER_FAIL_CODE, 6'h2, 16'h0050);
        i_probe_valid <= 1'b0;
        ep(4, 2);
        ent(0, POWER_FAIL_CODE, 6'h2, 16'h8000);
        i_probe_valid <= 1'b1;
        wr(REG_PF_MIN, 32'h0);
        ep(4, 3);
        cnt(4'h5);
    endtask : s_pf
    task automatic s_ext();
        wr(REG_EXT_MODE, 32'h4);
        wr(REG_EXT_MIN, 32'h1);
        ep(5, 1);
        cnt(4'h5);
        ep(5, 2);
        ent(0, EXTERNAL_ALARM_CODE, 6'h2, 16'h0050);
        wr(REG_EXT_MODE, 32'h5);
        ep(5, 2);
        cnt(4'h7);
        wr(REG_EXT_MODE, 32'h3);
        ep(5, 5);
        cnt(4'h7);
        wr(REG_EXT_MODE, 32'h4);
        wr(REG_EXT_MIN, 32'h0);
        ep(5, 5);
        cnt(4'h7);
    endtask : s_ext
    task automatic s_mains();
        wr(REG_PF_MIN, 32'h1);
        @(posedge i_clk_sys);
        i_probe_temp <= 16'h0100;
        i_temp_alarm[0] <= 1'b1;
        tk(3);
        ticks(2);
        i_mains_ok <= 1'b0;
        tk(3);
        ticks(3);
        i_mains_ok <= 1'b1;
        tk(3);
        ticks(2);
        i_temp_alarm[0] <= 1'b0;
        tk(6);
        ent(2, FIRST_HIGH_TEMP_CODE, 6'h2, 16'h0100);
        ent(1, POWER_FAIL_CODE, 6'h3, 16'h0100);
        ent(0, FIRST_HIGH_TEMP_CODE, 6'h2, 16'h0100);
        ep(0, 2);
        cnt(4'hA);
        rd(REG_LOST, 32'h1);
        rd(REG_STATUS, 32'h1A);
        wr(REG_CTRL, 32'h5);
        rd(REG_LOST, 32'h0);
    endtask : s_mains
    task automatic s_keys();
        wr(REG_KEY_FUNC, 32'h76);
        key(1, DISP_NONE, 10);
        key(1, DISP_REC_OFF, 26);
        rd(REG_CTRL, 32'h0);
        chk("rec enable", 32'h0, {31'h0, o_rec_enable});
        ep(0, 2);
        rd(REG_LOST, 32'h0);
        key(1, DISP_REC_ON, 26);
        key(0, DISP_DASHES, 26);
        cnt(4'h0);
        rd(8'h40, 32'h0);
        ep(0, 2);
        cnt(4'h1);
        wr(REG_CTRL, 32'h3);
        cnt(4'h0);
    endtask : s_keys
    initial begin
        tk(6);
        i_reset <= 1'b0;
        s_temp();
        s_pf();
        s_ext();
        s_mains();
        s_keys();
        stop_test();
    end
endmodule : test_alarm_event_recorder
`default_nettype wire
